// File: rtl/mxs_exec.sv
// execution logic for the swap/mask/row-step-with-skip instruction pair
// assumes one instruction per valid cycle from decode, a RAM whose read
// data follows ram_pointer in the same cycle, and one clock domain
//
// Contract
// - swap accumulator with pointed RAM nibble at once
// - column pointer becomes itself xor immediate
// - increment row; skip next when row zero
// - decrement row; skip next when row fifteen
// - increment opcode is upper six bits 101110
`timescale 1ns/10ps

module mxs_exec
    import mxs_pkg::*;
(
    // clock and reset
    input  wire logic                   clock,
    input  wire logic                   rst,
    // instruction from decode
    input  wire logic                   instr_valid,
    input  wire logic [INSTR_WIDTH-1:0] instr_word,
    // writes from the rest of the core
    input  wire mxs_load_type           core_load,
    // data RAM
    input  wire logic [3:0]             pointed_ram_nibble,
    output logic      [7:0]             ram_pointer,
    output logic                        ram_wr_en,
    output logic      [3:0]             ram_wr_data,
    // architectural state and sequencing
    output logic      [3:0]             acc_value,
    output logic      [3:0]             col_value,
    output logic      [3:0]             row_value,
    output logic                        skip_active,
    output logic                        exec_enable
);

    // ------------------------------------------------------------
    // decode
    // ------------------------------------------------------------
    mxs_state_type state_reg;
    mxs_state_type state_next;
    mxs_instr_type instr;
    logic          run;
    logic          is_inc;
    logic          is_dec;
    logic [3:0]    row_step;

    // the whole word is split into opcode and immediate fields
    assign instr  = mxs_instr_type'(instr_word);
    // a skipped slot still arrives from fetch but must not execute
    assign run    = instr_valid & ~state_reg.skip;
    assign is_inc = run & (instr.opcode == OPCODE_INC);
    assign is_dec = run & (instr.opcode == OPCODE_DEC);

    // row step result, used both for the write back and the skip test
    always_comb begin
        if (is_dec) begin
            row_step = state_reg.row - ROW_ONE;
        end else begin
            row_step = state_reg.row + ROW_ONE;
        end
    end

    // ------------------------------------------------------------
    // next state
    // ------------------------------------------------------------
    // core loads and the pair never meet in one slot in a sane core;
    // the pair wins so its swap cannot be half undone
    always_comb begin
        state_next = state_reg;
        if (instr_valid) begin
            state_next.skip = 1'b0;
        end
        if (is_inc || is_dec) begin
            state_next.acc  = pointed_ram_nibble;
            state_next.col  = state_reg.col ^ instr.imm;
            state_next.row  = row_step;
            if (is_inc) begin
                state_next.skip = (row_step == ROW_INC_SKIP);
            end else begin
                state_next.skip = (row_step == ROW_DEC_SKIP);
            end
        end else if (run) begin
            if (core_load.acc_we) begin
                state_next.acc = core_load.acc_data;
            end
            if (core_load.col_we) begin
                state_next.col = core_load.col_data;
            end
            if (core_load.row_we) begin
                state_next.row = core_load.row_data;
            end
        end
    end

    // single register stage for all state
    always_ff @(posedge clock) begin
        if (rst) begin
            state_reg <= '{acc: ACC_RESET, col: COL_RESET,
                           row: ROW_RESET, skip: 1'b0};
        end else begin
            state_reg <= state_next;
        end
    end

    // ------------------------------------------------------------
    // outputs
    // ------------------------------------------------------------
    // old accumulator goes to RAM while the old nibble comes back
    assign ram_pointer = {state_reg.col, state_reg.row};
    assign ram_wr_en   = is_inc | is_dec;
    assign ram_wr_data = state_reg.acc;
    assign acc_value   = state_reg.acc;
    assign col_value   = state_reg.col;
    assign row_value   = state_reg.row;
    assign skip_active = state_reg.skip;
    // the rest of the core gates its own writes and flags with this
    assign exec_enable = run;

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    logic pair_op;
    assign pair_op = instr_valid & ~state_reg.skip &
        (instr.opcode == OPCODE_INC || instr.opcode == OPCODE_DEC);

    chk_swap_acc_ram: assert property (
        @(posedge clock) disable iff (rst)
        pair_op |-> ram_wr_en && ram_wr_data == acc_value
            ##1 acc_value == $past(pointed_ram_nibble))
        else $error("swap did not exchange accumulator and RAM");

    chk_col_xor_imm: assert property (
        @(posedge clock) disable iff (rst)
        pair_op |=> col_value == ($past(col_value) ^ $past(instr.imm)))
        else $error("column pointer not xored with immediate");

    chk_inc_row_skip: assert property (
        @(posedge clock) disable iff (rst)
        (pair_op && instr.opcode == OPCODE_INC) |=>
            row_value == 4'($past(row_value) + 4'h1) &&
            skip_active == (row_value == 4'h0))
        else $error("increment step or its skip is wrong");

    chk_dec_row_skip: assert property (
        @(posedge clock) disable iff (rst)
        (pair_op && instr.opcode == OPCODE_DEC) |=>
            row_value == 4'($past(row_value) - 4'h1) &&
            skip_active == (row_value == 4'hf))
        else $error("decrement step or its skip is wrong");

    chk_inc_decode: assert property (
        @(posedge clock) disable iff (rst)
        (instr_valid && !skip_active &&
         instr_word[9:4] == 6'b101110) |-> ram_wr_en)
        else $error("increment opcode not recognised");

    chk_skip_no_change: assert property (
        @(posedge clock) disable iff (rst)
        (instr_valid && skip_active) |-> !ram_wr_en && !exec_enable
            ##1 $stable(acc_value) && $stable(col_value) &&
            $stable(row_value) && !skip_active)
        else $error("skipped instruction changed state");

    chk_skip_holds: assert property (
        @(posedge clock) disable iff (rst)
        (skip_active && !instr_valid) |=> skip_active)
        else $error("skip lost before the next instruction");

    chk_no_pair_no_wr: assert property (
        @(posedge clock) disable iff (rst)
        !pair_op |-> !ram_wr_en)
        else $error("RAM written outside the instruction pair");

    // ------------------------------------------------------------
    // checks on loads from the rest of the core
    // ------------------------------------------------------------
    // a load only lands in a slot that executes and is not the pair;
    // a suppressed slot must drop it, or a skip would leak state
    chk_acc_load_apply: assert property (
        @(posedge clock) disable iff (rst)
        (exec_enable && !ram_wr_en && core_load.acc_we) |=>
            acc_value == $past(core_load.acc_data))
        else $error("accumulator load not applied");

    chk_col_load_apply: assert property (
        @(posedge clock) disable iff (rst)
        (exec_enable && !ram_wr_en && core_load.col_we) |=>
            col_value == $past(core_load.col_data))
        else $error("column load not applied");

    chk_row_load_apply: assert property (
        @(posedge clock) disable iff (rst)
        (exec_enable && !ram_wr_en && core_load.row_we) |=>
            row_value == $past(core_load.row_data))
        else $error("row load not applied");

    chk_idle_no_exec: assert property (
        @(posedge clock) disable iff (rst)
        !instr_valid |-> !exec_enable && !ram_wr_en)
        else $error("execution seen in an idle slot");

    // ------------------------------------------------------------
    // checks on the RAM side and on reset
    // ------------------------------------------------------------
    // the write data must be the old accumulator, never the new one,
    // else the swap degenerates into a plain copy
    chk_wr_data_acc: assert property (
        @(posedge clock) disable iff (rst)
        ram_wr_en |-> ram_wr_data == acc_value)
        else $error("RAM write data is not the accumulator");

    chk_pointer_regs: assert property (
        @(posedge clock) disable iff (rst)
        ram_pointer == {col_value, row_value})
        else $error("RAM pointer does not follow column and row");

    // no disable here: this one watches the reset itself
    chk_reset_clear: assert property (
        @(posedge clock)
        rst |=> acc_value == ACC_RESET && col_value == COL_RESET &&
            row_value == ROW_RESET && !skip_active)
        else $error("state not cleared by reset");

endmodule

// File: rtl/mxs_pkg.sv
// package for the swap, mask and row-step skip instruction block
// assumes a 10-bit instruction word and 4-bit data paths in the core
package mxs_pkg;

    // ------------------------------------------------------------
    // instruction word layout
    // ------------------------------------------------------------
    localparam int          INSTR_WIDTH  = 10;
    localparam int          OPCODE_LSB   = 4;
    localparam int          IMM_LSB      = 0;
    localparam logic [5:0]  OPCODE_INC   = 6'h2e;  // 1 0 1 1 1 0
    localparam logic [5:0]  OPCODE_DEC   = 6'h2d;  // decrement variant

    // ------------------------------------------------------------
    // reset values and wrap points
    // ------------------------------------------------------------
    localparam logic [3:0]  ACC_RESET    = 4'h0;
    localparam logic [3:0]  COL_RESET    = 4'h0;
    localparam logic [3:0]  ROW_RESET    = 4'h0;
    localparam logic [3:0]  ROW_ONE      = 4'h1;
    localparam logic [3:0]  ROW_INC_SKIP = 4'h0;
    localparam logic [3:0]  ROW_DEC_SKIP = 4'hf;

    // ------------------------------------------------------------
    // carriers
    // ------------------------------------------------------------
    typedef struct packed {
        logic [5:0] opcode;
        logic [3:0] imm;
    } mxs_instr_type;

    // writes to the pointer and accumulator from the rest of the core
    typedef struct packed {
        logic       acc_we;
        logic [3:0] acc_data;
        logic       col_we;
        logic [3:0] col_data;
        logic       row_we;
        logic [3:0] row_data;
    } mxs_load_type;

    typedef struct packed {
        logic [3:0] acc;
        logic [3:0] col;
        logic [3:0] row;
        logic       skip;
    } mxs_state_type;

endpackage

// File: verification/tb_top.sv
// self-checking bench for the swap, mask and row-step skip block
// assumes rtl/mxs_pkg.sv and rtl/mxs_exec.sv; one 20 MHz clock, no partner
`timescale 1ns/10ps

module tb_top
    import mxs_pkg::*;
;
    // ------------------------------------------------------------
    // signals and reference state
    // ------------------------------------------------------------
    logic                   clock;
    logic                   rst;
    logic                   instr_valid;
    logic [INSTR_WIDTH-1:0] instr_word;
    mxs_load_type           core_load;
    logic [3:0]             pointed_ram_nibble;
    logic [7:0]             ram_pointer;
    logic                   ram_wr_en;
    logic [3:0]             ram_wr_data;
    logic [3:0]             acc_value;
    logic [3:0]             col_value;
    logic [3:0]             row_value;
    logic                   skip_active;
    logic                   exec_enable;
    int                     m_acc, m_col, m_row, m_skip;
    int                     err_count = 0;
    int                     tests_run = 0;

    mxs_exec i_mxs_exec (
        .clock              (clock),
        .rst                (rst),
        .instr_valid        (instr_valid),
        .instr_word         (instr_word),
        .core_load          (core_load),
        .pointed_ram_nibble (pointed_ram_nibble),
        .ram_pointer        (ram_pointer),
        .ram_wr_en          (ram_wr_en),
        .ram_wr_data        (ram_wr_data),
        .acc_value          (acc_value),
        .col_value          (col_value),
        .row_value          (row_value),
        .skip_active        (skip_active),
        .exec_enable        (exec_enable)
    );

    // free-running core clock, 50 ns period
    initial begin
        clock = 1'b0;
        forever #25 clock = ~clock;
    end

    task automatic cmp(input logic [7:0] got, input logic [7:0] exp,
                       input string what);
        tests_run++;
        if (got !== exp) begin
            err_count++;
            $display("CHECK FAILED at %0t: %s got %h exp %h",
                     $time, what, got, exp);
        end
    endtask

    // one instruction slot; state from the previous slot is checked first,
    // combinational answers are checked mid-cycle, then the model steps
    task automatic step(input logic v, input logic [5:0] op,
                        input logic [3:0] imm, input logic [14:0] ld,
                        input logic [3:0] nib);
        logic         inc;
        logic         pair;
        mxs_load_type l;
        l = mxs_load_type'(ld);
        @(posedge clock);
        instr_valid        <= v;
        instr_word         <= {op, imm};
        core_load          <= l;
        pointed_ram_nibble <= nib;
        @(negedge clock);
        inc  = (op == OPCODE_INC);
        pair = v && !m_skip && (inc || op == OPCODE_DEC);
        cmp(8'(acc_value), 8'(m_acc), "acc");
        cmp(8'(col_value), 8'(m_col), "col");
        cmp(8'(row_value), 8'(m_row), "row");
        cmp(8'(skip_active), 8'(m_skip), "skip");
        cmp(ram_pointer, 8'(m_col * 16 + m_row), "pointer");
        cmp(8'(exec_enable), 8'(v && !m_skip), "exec");
        cmp(8'(ram_wr_en), 8'(pair), "wr_en");
        if (pair) cmp(8'(ram_wr_data), 8'(m_acc), "wr_data");
        if (v && m_skip) m_skip = 0;
        else if (pair) begin
            m_acc  = nib;
            m_col  = m_col ^ imm;
            m_row  = (m_row + (inc ? 1 : 15)) % 16;
            m_skip = inc ? (m_row == 0) : (m_row == 15);
        end else if (v) begin
            if (l.acc_we) m_acc = l.acc_data;
            if (l.col_we) m_col = l.col_data;
            if (l.row_we) m_row = l.row_data;
        end
    endtask

    // reset held four cycles with no instruction presented
    task automatic do_reset();
        rst <= 1'b1;
        instr_valid <= 1'b0;
        repeat (4) @(posedge clock);
        rst <= 1'b0;
        {m_acc, m_col, m_row, m_skip} = '0;
    endtask

    task automatic close_out();
        $display("checks %0d mismatches %0d", tests_run, err_count);
        if (err_count == 0 && tests_run > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask

    // ------------------------------------------------------------
    // directed wraps, suppression, then random traffic
    // ------------------------------------------------------------
    initial begin
        logic [5:0] op;
        rst = 1'b1;
        instr_valid = 1'b0;
        instr_word = '0;
        core_load = '0;
        pointed_ram_nibble = '0;
        void'($urandom(25053));
        do_reset();
        step(1, 6'h00, 4'h0, 15'h001f, 4'h0);
        step(1, OPCODE_INC, 4'h5, 15'h0, 4'ha);
        step(0, OPCODE_INC, 4'h0, 15'h0, 4'h0);
        step(1, OPCODE_INC, 4'h3, 15'h7fff, 4'h6);
        step(1, OPCODE_DEC, 4'h9, 15'h0, 4'h2);
        step(1, OPCODE_DEC, 4'hc, 15'h0, 4'h3);
        for (int i = 0; i < 600; i++) begin
            case ($urandom % 4)
                0: op = OPCODE_INC;
                1: op = OPCODE_DEC;
                default: op = 6'($urandom);
            endcase
            step(($urandom % 5) != 0, op, 4'($urandom), 15'($urandom),
                 4'($urandom));
            if (i == 300) do_reset();
        end
        step(0, 6'h00, 4'h0, 15'h0, 4'h0);
        close_out();
    end

    // cut a hang short well past the expected 607 slots
    initial begin
        repeat (3000) @(posedge clock);
        err_count++;
        close_out();
    end

endmodule
